// file: pkg/tfc_pkg.sv
// Shared constants for the temperature result formatter and its host
package tfc_pkg;
  // Device register map
  localparam logic [7:0] TFC_REG_LOCAL = 8'h00;
  localparam logic [7:0] TFC_REG_REMOTE_HI = 8'h01;
  localparam logic [7:0] TFC_REG_CFG_RD = 8'h03;
  localparam logic [7:0] TFC_REG_CFG_WR = 8'h09;
  localparam logic [7:0] TFC_REG_REMOTE_LO = 8'h10;
  localparam int TFC_REG_COUNT = 22;
  localparam logic [7:0] TFC_PTR_RESET = 8'h00;
  localparam logic [7:0] TFC_TEMP_RESET = 8'h00;
  localparam logic [7:0] TFC_CFG_RESET = 8'h00;
  // Configuration fields
  localparam int TFC_CFG_MASK_BIT = 7;
  localparam int TFC_CFG_STANDBY_BIT = 6;
  localparam int TFC_CFG_PINFN_BIT = 5;
  localparam int TFC_CFG_RANGE_BIT = 2;
  localparam logic [7:0] TFC_CFG_USED = 8'he4;
  // Formats
  localparam logic signed [9:0] TFC_EXT_OFFSET = 10'sh040;
  localparam logic signed [9:0] TFC_BIN_MAX = 10'sh07f;
  localparam logic signed [9:0] TFC_OFS_MAX = 10'sh0ff;
  localparam logic [7:0] TFC_FRAC_MASK = 8'hc0;
  // Link
  localparam logic [6:0] TFC_DEV_ADDR = 7'h4c;
  localparam logic [3:0] TFC_BITS_PER_BYTE = 4'h8;
  // Host register map (byte addresses on the AHB-Lite bus)
  localparam logic [7:0] TFC_H_CMD = 8'h00;
  localparam logic [7:0] TFC_H_XFER = 8'h04;
  localparam logic [7:0] TFC_H_STATUS = 8'h08;
  localparam int TFC_H_CMD_GO_BIT = 0;
  localparam int TFC_H_CMD_OP_LSB = 1;
  localparam int TFC_H_ST_BUSY_BIT = 0;
  localparam int TFC_H_ST_NACK_BIT = 1;
  localparam int TFC_H_RDATA_LSB = 8;
  localparam int TFC_H_WDATA_LSB = 8;
  localparam logic [31:0] TFC_H_RESET = 32'h0000_0000;
  // Timing
  localparam int TFC_CLK_MHZ = 100;
  localparam int TFC_SCL_PERIOD_NS = 10000;
  localparam int TFC_SCL_QTR_CYCLES = TFC_SCL_PERIOD_NS * TFC_CLK_MHZ / 4000;

  typedef enum logic [1:0] {
    TFC_OP_PTR = 2'b00,
    TFC_OP_WRITE = 2'b01,
    TFC_OP_READ = 2'b10
  } tfc_op_t;
endpackage : tfc_pkg

// file: pkg/tfc_link_if.sv
// Two-wire link between the host controller and the temperature device
`timescale 1ns/1ps
interface tfc_link_if;
  logic scl;
  logic host_sda_oe;
  logic host_sda_out;
  logic dev_sda_oe;
  logic dev_sda_out;
  logic sda;

  // Open drain: any enabled driver with a low output pulls low, else pulled up
  assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

  modport host (output scl, output host_sda_oe, output host_sda_out,
    input sda);
  modport device (input scl, output dev_sda_oe, output dev_sda_out,
    input sda);
endinterface : tfc_link_if

// file: rtl/tfc_device.sv
// Device end: register file, result formatting and two-wire slave
`timescale 1ns/1ps
module tfc_device #(
  parameter logic [6:0] DEV_ADDR = tfc_pkg::TFC_DEV_ADDR
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  tfc_link_if.device LINK,
  input wire logic CONV_DONE,
  input wire logic signed [9:0] LOCAL_TEMP,
  input wire logic signed [11:0] REMOTE_QTR,
  input wire logic REMOTE_SHORT,
  input wire logic ALARM_REQ,
  input wire logic HIGH_LIMIT_REQ,
  input wire logic OVERHEAT_REQ,
  output logic CONV_RUN,
  output logic PIN6_N,
  output logic OVERHEAT_OUT_N
);
  import tfc_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_WDATA = 3'b010,
    S_RDATA = 3'b011,
    S_ACK_TX = 3'b100,
    S_ACK_RX = 3'b101,
    S_IGNORE = 3'b110
  } tfc_dev_state_t;

  // Saturating formatter; returns the high byte for either scale
  function automatic logic [7:0] fmt(input logic signed [9:0] t,
                                     input logic ext);
    logic signed [9:0] v;
    v = ext ? t + TFC_EXT_OFFSET : t;
    if (v < 10'sd0) fmt = 8'h00;
    else if (!ext && v > TFC_BIN_MAX) fmt = TFC_BIN_MAX[7:0];
    else if (v > TFC_OFS_MAX) fmt = TFC_OFS_MAX[7:0];
    else fmt = v[7:0];
  endfunction : fmt

  logic [7:0] local_temperature_value;
  logic [7:0] remote_temperature_high_byte;
  logic [7:0] remote_temperature_low_byte;
  logic [7:0] configuration;
  logic [7:0] register_pointer;
  logic high_frozen;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  tfc_dev_state_t state;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic is_read;
  logic first_byte;
  logic master_nack;
  logic sda_oe;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] read_byte;
  logic ext_range;
  logic signed [9:0] remote_int;
  logic remote_sat;
  logic conv_take;

  // Two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], LINK.scl};
      sda_s <= {sda_s[1:0], LINK.sda};
    end
  end

  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start_seen = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_seen = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  assign ext_range = configuration[TFC_CFG_RANGE_BIT];
  assign remote_int = 10'(REMOTE_QTR >>> 2);
  assign remote_sat = ext_range
    ? (remote_int + TFC_EXT_OFFSET < 10'sd0) ||
      (remote_int + TFC_EXT_OFFSET > TFC_OFS_MAX)
    : (remote_int < 10'sd0) || (remote_int > TFC_BIN_MAX);

  // Range is read at the moment each result lands, so the
  // first result after a switch already uses the new scale
  assign conv_take = CONV_DONE & ~configuration[TFC_CFG_STANDBY_BIT];

  // Converter-only temperature registers
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      local_temperature_value <= TFC_TEMP_RESET;
      remote_temperature_high_byte <= TFC_TEMP_RESET;
      remote_temperature_low_byte <= TFC_TEMP_RESET;
    end else if (conv_take) begin
      local_temperature_value <= fmt(LOCAL_TEMP, ext_range);
      if (!REMOTE_SHORT) begin
        if (!high_frozen)
          remote_temperature_high_byte <= fmt(remote_int, ext_range);
        remote_temperature_low_byte <= remote_sat ? 8'h00
          : {REMOTE_QTR[1:0], 6'h00} & TFC_FRAC_MASK;
      end
    end
  end

  // Read of the low byte locks the high byte until it is read
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) high_frozen <= 1'b0;
    else if (rd_strobe && register_pointer == TFC_REG_REMOTE_LO)
      high_frozen <= 1'b1;
    else if (rd_strobe && register_pointer == TFC_REG_REMOTE_HI)
      high_frozen <= 1'b0;
  end

  // Configuration; limit registers are not modelled, so nothing
  // rewrites them on a range change
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) configuration <= TFC_CFG_RESET;
    else if (wr_strobe && register_pointer == TFC_REG_CFG_WR)
      configuration <= shreg & TFC_CFG_USED;
  end

  // Read mux; unmodelled addresses read zero
  always_comb begin
    case (register_pointer)
      TFC_REG_LOCAL: read_byte = local_temperature_value;
      TFC_REG_REMOTE_HI: read_byte = remote_temperature_high_byte;
      TFC_REG_CFG_RD: read_byte = configuration & TFC_CFG_USED;
      TFC_REG_REMOTE_LO: read_byte = remote_temperature_low_byte;
      default: read_byte = 8'h00;
    endcase
  end

  assign wr_strobe = scl_fall && state == S_WDATA &&
                     bitcnt == TFC_BITS_PER_BYTE && !first_byte;
  assign rd_strobe = scl_fall && is_read &&
    ((state == S_ACK_TX) || (state == S_ACK_RX && !master_nack));

  // Pointer takes the first byte of each write
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) register_pointer <= TFC_PTR_RESET;
    else if (scl_fall && state == S_WDATA &&
             bitcnt == TFC_BITS_PER_BYTE && first_byte)
      register_pointer <= shreg;
  end

  // Two-wire slave; serial access never depends on standby
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      is_read <= 1'b0;
      first_byte <= 1'b0;
      master_nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      state <= S_ADDR;
      bitcnt <= 4'h0;
      first_byte <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state <= S_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        S_ADDR, S_WDATA: begin
          shreg <= {shreg[6:0], sda_s[1]};
          bitcnt <= bitcnt + 4'h1;
        end
        S_RDATA: bitcnt <= bitcnt + 4'h1;
        S_ACK_RX: master_nack <= sda_s[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        S_ADDR: if (bitcnt == TFC_BITS_PER_BYTE) begin
          if (shreg[7:1] == DEV_ADDR) begin
            is_read <= shreg[0];
            sda_oe <= 1'b1;
            state <= S_ACK_TX;
          end else state <= S_IGNORE;
        end
        S_WDATA: if (bitcnt == TFC_BITS_PER_BYTE) begin
          first_byte <= 1'b0;
          sda_oe <= 1'b1;
          state <= S_ACK_TX;
        end
        S_ACK_TX: begin
          bitcnt <= 4'h0;
          if (is_read) begin
            sda_oe <= ~read_byte[7];
            shreg <= {read_byte[6:0], 1'b0};
            state <= S_RDATA;
          end else begin
            sda_oe <= 1'b0;
            state <= S_WDATA;
          end
        end
        S_RDATA: if (bitcnt == TFC_BITS_PER_BYTE) begin
          sda_oe <= 1'b0;
          state <= S_ACK_RX;
        end else begin
          sda_oe <= ~shreg[7];
          shreg <= {shreg[6:0], 1'b0};
        end
        S_ACK_RX: if (!master_nack) begin
          bitcnt <= 4'h0;
          sda_oe <= ~read_byte[7];
          shreg <= {read_byte[6:0], 1'b0};
          state <= S_RDATA;
        end else state <= S_IGNORE;
        default: ;
      endcase
    end
  end

  assign LINK.dev_sda_oe = sda_oe;
  assign LINK.dev_sda_out = 1'b0;

  // Outputs follow config and requests in every mode
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PIN6_N <= 1'b1;
      OVERHEAT_OUT_N <= 1'b1;
      CONV_RUN <= 1'b0;
    end else begin
      if (configuration[TFC_CFG_PINFN_BIT])
        PIN6_N <= ~HIGH_LIMIT_REQ;
      else
        PIN6_N <= ~(ALARM_REQ & ~configuration[TFC_CFG_MASK_BIT]);
      OVERHEAT_OUT_N <= ~OVERHEAT_REQ;
      CONV_RUN <= ~configuration[TFC_CFG_STANDBY_BIT];
    end
  end
endmodule : tfc_device

// file: rtl/tfc_host.sv
// Host end: AHB-Lite command registers and two-wire master
`timescale 1ns/1ps
module tfc_host #(
  parameter int QTR_CYCLES = tfc_pkg::TFC_SCL_QTR_CYCLES,
  parameter logic [6:0] DEV_ADDR = tfc_pkg::TFC_DEV_ADDR
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  tfc_link_if.host LINK,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA
);
  import tfc_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } tfc_host_state_t;

  logic [15:0] qcnt;
  logic qtick;
  logic [1:0] phase;
  tfc_host_state_t state;
  logic [15:0] xfer;
  tfc_op_t op;
  logic busy;
  logic nack;
  logic [7:0] rdata;
  logic [1:0] bi;
  logic [3:0] k;
  logic scl;
  logic sda_oe;
  logic [1:0] sda_s;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [7:0] cur_byte;
  logic rx_byte;
  logic last_byte;

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Address phase captured for the following data phase
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (HREADY) begin
      dp_write <= HSEL & HTRANS[1] & HWRITE;
      dp_addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) HRDATA <= TFC_H_RESET;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        TFC_H_XFER: HRDATA <= {16'h0000, xfer};
        TFC_H_STATUS: HRDATA <= {16'h0000, rdata, 6'h00, nack, busy};
        default: HRDATA <= TFC_H_RESET;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) xfer <= 16'h0000;
    else if (dp_write && dp_addr == TFC_H_XFER && !busy)
      xfer <= HWDATA[15:0];
  end

  // Quarter-bit enable from the divider
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) qcnt <= 16'h0000;
    else if (state == H_IDLE || qtick) qcnt <= 16'h0000;
    else qcnt <= qcnt + 16'h0001;
  end
  assign qtick = (qcnt == 16'(QTR_CYCLES - 1));

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) sda_s <= 2'b11;
    else sda_s <= {sda_s[0], LINK.sda};
  end

  // Byte sequence: address, then pointer (and data for a write), or one read byte
  always_comb begin
    cur_byte = 8'h00;
    rx_byte = 1'b0;
    case (bi)
      2'd0: cur_byte = {DEV_ADDR, op == TFC_OP_READ};
      2'd1: begin
        cur_byte = xfer[7:0];
        rx_byte = (op == TFC_OP_READ);
      end
      default: cur_byte = xfer[15:8];
    endcase
  end
  assign last_byte = (bi == 2'd2) || (bi == 2'd1 && op != TFC_OP_WRITE);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= H_IDLE;
      phase <= 2'b00;
      op <= TFC_OP_PTR;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
      bi <= 2'd0;
      k <= 4'h0;
      scl <= 1'b1;
      sda_oe <= 1'b0;
    end else if (state == H_IDLE) begin
      if (dp_write && dp_addr == TFC_H_CMD && HWDATA[TFC_H_CMD_GO_BIT]) begin
        op <= tfc_op_t'(HWDATA[TFC_H_CMD_OP_LSB +: 2]);
        busy <= 1'b1;
        nack <= 1'b0;
        phase <= 2'b00;
        state <= H_START;
      end
    end else if (qtick) begin
      phase <= phase + 2'b01;
      case (state)
        H_START: case (phase)
          2'b01: sda_oe <= 1'b1;
          2'b10: scl <= 1'b0;
          2'b11: begin
            bi <= 2'd0;
            k <= 4'h0;
            state <= H_BIT;
          end
          default: ;
        endcase
        H_BIT: case (phase)
          2'b00: sda_oe <= (!rx_byte && k < TFC_BITS_PER_BYTE)
                           ? ~cur_byte[3'(7 - k)] : 1'b0;
          2'b01: scl <= 1'b1;
          2'b10: begin
            if (rx_byte && k < TFC_BITS_PER_BYTE)
              rdata <= {rdata[6:0], sda_s[1]};
            if (!rx_byte && k == TFC_BITS_PER_BYTE && sda_s[1])
              nack <= 1'b1;
          end
          default: begin
            scl <= 1'b0;
            if (k == TFC_BITS_PER_BYTE) begin
              k <= 4'h0;
              if (nack || last_byte) state <= H_STOP;
              else bi <= bi + 2'd1;
            end else k <= k + 4'h1;
          end
        endcase
        H_STOP: case (phase)
          2'b00: sda_oe <= 1'b1;
          2'b01: scl <= 1'b1;
          2'b10: sda_oe <= 1'b0;
          default: begin
            busy <= 1'b0;
            state <= H_IDLE;
          end
        endcase
        default: state <= H_IDLE;
      endcase
    end
  end

  assign LINK.scl = scl;
  assign LINK.host_sda_oe = sda_oe;
  assign LINK.host_sda_out = 1'b0;
endmodule : tfc_host

// file: testbench/tfc_checker.sv
// Concurrent checks on the two-wire link and the device pin outputs
`timescale 1ns/1ps
module tfc_checker (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic host_sda_out,
  input wire logic dev_sda_oe,
  input wire logic dev_sda_out,
  input wire logic sda,
  input wire logic OVERHEAT_REQ,
  input wire logic ALARM_REQ,
  input wire logic HIGH_LIMIT_REQ,
  input wire logic OVERHEAT_OUT_N,
  input wire logic PIN6_N,
  input wire logic CONV_RUN
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  reset_idle_a:
    assert property ($rose(ARST_N) |-> scl && !host_sda_oe && !dev_sda_oe)
    else $error("Link not idle after reset");
  // Both ends may overlap only while the clock is low
  open_drain_a:
    assert property (!host_sda_out && !dev_sda_out &&
      !(scl && host_sda_oe && dev_sda_oe))
    else $error("Data line driven high or by both ends");
  dev_edge_a:
    assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("Device moved data while clock high");
  start_host_a:
    assert property ($fell(sda) && scl && $past(scl) |-> host_sda_oe)
    else $error("Start not made by host");
  // Device samples through a synchroniser, so short phases are lost
  scl_low_a:
    assert property ($fell(scl) |=> !scl [*3])
    else $error("Link clock low phase too short");
  overheat_a:
    assert property ($past(ARST_N) |-> OVERHEAT_OUT_N == !$past(OVERHEAT_REQ))
    else $error("Overheat output does not follow request");
  pin_idle_a:
    assert property ((!ALARM_REQ && !HIGH_LIMIT_REQ) [*2] |-> PIN6_N)
    else $error("Pin six asserted with no request");
  conv_run_a:
    assert property ($rose(ARST_N) |=> CONV_RUN)
    else $error("Conversions not running after reset");
  cover property (scl && $fell(sda));
  cover property ($rose(dev_sda_oe));
  cover property ($fell(CONV_RUN));
endmodule : tfc_checker

// file: testbench/tb_temp_result_format_config.sv
// Bench joining host and device over the link, driven through AHB-Lite
`timescale 1ns/1ps
module tb_temp_result_format_config;
  import tfc_pkg::*;
  localparam int QTR = 4;
  logic MCLK = 0, ARST_N = 0, HSEL = 1, HWRITE = 0, CONV_DONE = 0;
  logic REMOTE_SHORT = 0, ALARM_REQ = 0, HIGH_LIMIT_REQ = 0;
  logic OVERHEAT_REQ = 0, HREADYOUT, HRESP, CONV_RUN, PIN6_N, OVERHEAT_OUT_N;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
  logic [1:0] HTRANS = 0;
  logic signed [9:0] LOCAL_TEMP = 0;
  logic signed [11:0] REMOTE_QTR = 0;
  int miscompares = 0, checks = 0;
  int seed = 32'ha912d3f0;
  int temps[8] = '{-55, 0, 1, 25, 127, 150, -70, 200};
  logic [7:0] seen, r;
  logic [7:0] notes[$];
  event result_ev;
  tfc_link_if link();
  tfc_host #(.QTR_CYCLES(QTR)) u_tfc_host (.MCLK(MCLK), .ARST_N(ARST_N),
    .LINK(link.host), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA));
  tfc_device u_tfc_device (.MCLK(MCLK), .ARST_N(ARST_N), .LINK(link.device),
    .CONV_DONE(CONV_DONE), .LOCAL_TEMP(LOCAL_TEMP), .REMOTE_QTR(REMOTE_QTR),
    .REMOTE_SHORT(REMOTE_SHORT), .ALARM_REQ(ALARM_REQ),
    .HIGH_LIMIT_REQ(HIGH_LIMIT_REQ), .OVERHEAT_REQ(OVERHEAT_REQ),
    .CONV_RUN(CONV_RUN), .PIN6_N(PIN6_N), .OVERHEAT_OUT_N(OVERHEAT_OUT_N));
  tfc_checker u_tfc_checker (.MCLK(MCLK), .ARST_N(ARST_N), .scl(link.scl),
    .host_sda_oe(link.host_sda_oe), .host_sda_out(link.host_sda_out),
    .dev_sda_oe(link.dev_sda_oe), .dev_sda_out(link.dev_sda_out),
    .sda(link.sda), .OVERHEAT_REQ(OVERHEAT_REQ), .ALARM_REQ(ALARM_REQ),
    .HIGH_LIMIT_REQ(HIGH_LIMIT_REQ), .OVERHEAT_OUT_N(OVERHEAT_OUT_N),
    .PIN6_N(PIN6_N), .CONV_RUN(CONV_RUN));

  initial forever #5 MCLK = ~MCLK;

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    HTRANS <= 2'b10;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    rd = HRDATA;
  endtask : ahb

  // Busy may lag the command write, so see it rise before waiting it out
  task automatic op(input tfc_op_t o, input logic [7:0] p, d,
      output logic [7:0] res);
    logic [31:0] s;
    ahb(1'b1, TFC_H_XFER, {16'h0, d, p}, s);
    ahb(1'b1, TFC_H_CMD, (32'(o) << TFC_H_CMD_OP_LSB) | 32'h1, s);
    do ahb(1'b0, TFC_H_STATUS, 32'h0, s); while (!s[TFC_H_ST_BUSY_BIT]);
    do ahb(1'b0, TFC_H_STATUS, 32'h0, s); while (s[TFC_H_ST_BUSY_BIT]);
    check({7'h0, s[TFC_H_ST_NACK_BIT]}, 8'h00);
    res = s[TFC_H_RDATA_LSB +: 8];
  endtask : op

  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    notes.push_back(exp);
    op(TFC_OP_PTR, p, 8'h0, r);
    op(TFC_OP_READ, 8'h0, 8'h0, r);
    seen = r;
    -> result_ev;
  endtask : rd

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    op(TFC_OP_WRITE, p, d, r);
  endtask : wr

  task automatic conv(input int l, input int q);
    LOCAL_TEMP <= 10'(l);
    REMOTE_QTR <= 12'(q);
    CONV_DONE <= 1'b1;
    @(posedge MCLK);
    CONV_DONE <= 1'b0;
    repeat (2) @(posedge MCLK);
  endtask : conv

  function automatic logic [7:0] fmt(input int t, input bit ext);
    int v = ext ? t + 64 : t;
    int hi = ext ? 255 : 127;
    return 8'(v < 0 ? 0 : (v > hi ? hi : v));
  endfunction : fmt

  task automatic remote(input int q, input bit ext);
    int w = q >>> 2;
    int v = ext ? w + 64 : w;
    logic [7:0] lo = (v < 0 || v > (ext ? 255 : 127)) ? 8'h0 : 8'((q & 3) << 6);
    rd(TFC_REG_REMOTE_LO, lo);
    rd(TFC_REG_REMOTE_HI, fmt(w, ext));
  endtask : remote

  task automatic sweep(input bit ext);
    foreach (temps[i]) begin
      int q = temps[i] * 4 + ((temps[i] > 0 && temps[i] != 127) ? i % 4 : 0);
      conv(temps[i], q);
      rd(TFC_REG_LOCAL, fmt(temps[i], ext));
      remote(q, ext);
    end
  endtask : sweep

  initial forever begin
    @(result_ev);
    check(seen, notes.pop_front());
  end

  initial begin
    #950_000;
    miscompares++;
    complete_run();
  end

  initial begin
    int l, q;
    repeat (5) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    check({6'h0, link.scl, link.sda}, 8'h03);
    notes.push_back(TFC_TEMP_RESET);
    op(TFC_OP_READ, 8'h0, 8'h0, r);
    seen = r;
    -> result_ev;
    rd(TFC_REG_CFG_RD, TFC_CFG_RESET);
    rd(TFC_REG_REMOTE_HI, TFC_TEMP_RESET);
    rd(8'h05, 8'h00);
    check({7'h0, CONV_RUN}, 8'h01);
    check({7'h0, HRESP}, 8'h00);
    sweep(1'b0);
    // Reserved bits set on purpose to prove they are dropped
    wr(TFC_REG_CFG_WR, 8'h1f);
    rd(TFC_REG_CFG_RD, 8'h04);
    rd(TFC_REG_LOCAL, fmt(200, 1'b0));
    sweep(1'b1);
    repeat (4) begin
      l = {$random(seed)} % 256 - 64;
      q = {$random(seed)} % 604;
      conv(l, q);
      rd(TFC_REG_LOCAL, fmt(l, 1'b1));
      remote(q, 1'b1);
    end
    conv(10, 40);
    REMOTE_SHORT <= 1'b1;
    conv(10, 600);
    REMOTE_SHORT <= 1'b0;
    remote(40, 1'b1);
    rd(TFC_REG_REMOTE_LO, 8'h00);
    conv(20, 81);
    rd(TFC_REG_REMOTE_HI, fmt(10, 1'b1));
    conv(20, 81);
    remote(81, 1'b1);
    wr(TFC_REG_LOCAL, 8'h55);
    rd(TFC_REG_LOCAL, fmt(20, 1'b1));
    wr(TFC_REG_CFG_WR, 8'h44);
    check({7'h0, CONV_RUN}, 8'h00);
    conv(30, 120);
    rd(TFC_REG_LOCAL, fmt(20, 1'b1));
    OVERHEAT_REQ <= 1'b1;
    ALARM_REQ <= 1'b1;
    HIGH_LIMIT_REQ <= 1'b1;
    repeat (2) @(posedge MCLK);
    check({6'h0, OVERHEAT_OUT_N, PIN6_N}, 8'h00);
    wr(TFC_REG_CFG_WR, 8'hc4);
    check({7'h0, PIN6_N}, 8'h01);
    wr(TFC_REG_CFG_WR, 8'he4);
    check({7'h0, PIN6_N}, 8'h00);
    HIGH_LIMIT_REQ <= 1'b0;
    repeat (2) @(posedge MCLK);
    check({7'h0, PIN6_N}, 8'h01);
    wr(TFC_REG_CFG_WR, 8'h04);
    conv(30, 120);
    rd(TFC_REG_LOCAL, fmt(30, 1'b1));
    // Let the watcher take the last note before the run ends
    repeat (2) @(posedge MCLK);
    complete_run();
  end
endmodule : tb_temp_result_format_config
